// *** rtl/cmoc_regs.svh ***
// register offsets, field widths and codes of the message object controller
`ifndef CMOC_REGS_SVH
`define CMOC_REGS_SVH
`define CMOC_NOBJ 4
`define CMOC_ADDR_W 8
`define CMOC_FCC_OFF 8'h00
`define CMOC_FCV_OFF 8'h04
`define CMOC_IST_OFF 8'h08
`define CMOC_IMSK_OFF 8'h0C
`define CMOC_CTL_BASE 8'h10
`define CMOC_DAT_BASE 8'h20
`define CMOC_CTL_W 12
`define CMOC_FCC_W 5
`define CMOC_FCV_W 16
`define CMOC_IST_W 8
`define CMOC_MODE_MEAS 2'h2
`define CMOC_SUB_REC 3'h1
`define CMOC_SUB_ECHO_DOM 3'h2
`define CMOC_SUB_ECHO_REC 3'h3
`define CMOC_SUB_RESYNC 3'h4
`define CMOC_RESP_OK 2'h0
`define CMOC_RESP_ERR 2'h2
`endif

// *** rtl/cmoc_pkg.sv ***
// types shared by the message object controller
package cmoc_pkg;
    // per-object control and status word, valid in bit 0
    typedef struct packed {
        logic [2:0] obj_type;
        logic receive_pending_flag;
        logic message_lost_flag;
        logic new_data_flag;
        logic single_data_transfer;
        logic transmit_request_bit;
        logic transmit_enable_b;
        logic transmit_enable_a;
        logic receive_enable_bit;
        logic object_valid;
    } cmoc_obj_t;
    // frame counter control: mode in bits 1:0, sub-mode in bits 4:2
    typedef struct packed {
        logic [2:0] measurement_submode_select;
        logic [1:0] frame_counter_function_mode;
    } cmoc_fcc_t;
    // received frame handed over by the node for storage
    typedef struct packed {
        logic [1:0] idx;
        logic [31:0] data;
    } cmoc_rx_frame_t;
    // transmit sequencer states
    typedef enum logic [1:0] {
        CMOC_TX_IDLE = 2'b00,
        CMOC_TX_COPY = 2'b01,
        CMOC_TX_SEND = 2'b10
    } cmoc_tx_state_t;
endpackage

// *** rtl/cmoc_top.sv ***
// message object store, transmit sequencer and bit timing measurement
`include "cmoc_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module cmoc_top (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // node side, same clock
    input wire logic rx_store_valid,
    input wire cmoc_pkg::cmoc_rx_frame_t rx_store,
    input wire logic tx_level,
    input wire logic sample_point,
    input wire logic sync_qualify,
    input wire logic tx_done,
    output logic tx_req,
    output logic [31:0] tx_frame,
    // receive pin, asynchronous
    input wire logic rxd_pin,
    // interrupt
    output logic irq
);
    localparam int N = `CMOC_NOBJ;
    // reset release synchroniser
    logic rst_s1;
    logic rst_n;
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // ---------------- register bus ----------------
    logic aw_held, w_held, next_aw_held, next_w_held;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_bvalid, next_rvalid, next_arready;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic do_wr; // write performed this cycle
    logic wr_hit; // write address is mapped
    cmoc_pkg::cmoc_fcc_t fcc, next_fcc;
    logic [`CMOC_FCV_W-1:0] fcv, next_fcv;
    logic [`CMOC_IST_W-1:0] ist, next_ist, imsk, next_imsk, ist_set;
    cmoc_pkg::cmoc_obj_t obj [N];
    logic [31:0] obj_data [N];
    logic rd_hit;
    logic [31:0] rd_val;
    // read decode; unmapped offsets answer with slave error
    always_comb
    begin
        rd_hit = 1'b1;
        rd_val = 32'h0000_0000;
        if (s_axi_araddr == `CMOC_FCC_OFF)
            rd_val = {27'h000_0000, fcc};
        else if (s_axi_araddr == `CMOC_FCV_OFF)
            rd_val = {16'h0000, fcv};
        else if (s_axi_araddr == `CMOC_IST_OFF)
            rd_val = {24'h00_0000, ist};
        else if (s_axi_araddr == `CMOC_IMSK_OFF)
            rd_val = {24'h00_0000, imsk};
        else if (s_axi_araddr[7:4] == `CMOC_CTL_BASE >> 4 && s_axi_araddr[1:0] == 2'h0)
            rd_val = {20'h0_0000, obj[s_axi_araddr[3:2]]};
        else if (s_axi_araddr[7:4] == `CMOC_DAT_BASE >> 4 && s_axi_araddr[1:0] == 2'h0)
            rd_val = obj_data[s_axi_araddr[3:2]];
        else
            rd_hit = 1'b0;
    end
    // write and read channel handshakes; address and data taken in any order
    always_comb
    begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        next_arready = 1'b0;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        do_wr = aw_held && w_held && !s_axi_bvalid;
        wr_hit = aw_addr[1:0] == 2'h0 && (aw_addr <= `CMOC_IMSK_OFF
            || aw_addr[7:4] == `CMOC_CTL_BASE >> 4 || aw_addr[7:4] == `CMOC_DAT_BASE >> 4);
        if (do_wr)
        begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = wr_hit ? `CMOC_RESP_OK : `CMOC_RESP_ERR;
        end
        // one read under way: arready pulses only while idle
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rdata = rd_val;
            next_rresp = rd_hit ? `CMOC_RESP_OK : `CMOC_RESP_ERR;
        end
        else if (!s_axi_rvalid && !next_rvalid && s_axi_arvalid)
            next_arready = 1'b1;
    end
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CMOC_RESP_OK;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `CMOC_RESP_OK;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_arready <= 1'b0;
        end
        else if (clk_en)
        begin
            s_axi_awready <= !next_aw_held;
            s_axi_wready <= !next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
            s_axi_arready <= next_arready;
        end
    end
    // ready flops hold the inverse of the holding flags, so the bus sees flop outputs
    assign aw_held = !s_axi_awready;
    assign w_held = !s_axi_wready;

    // ---------------- transmit sequencer ----------------
    cmoc_pkg::cmoc_tx_state_t tx_state, next_tx_state;
    logic [1:0] cur, next_cur, first_idx;
    logic [N-1:0] pend;
    logic any_pend, copy_ok, send_ok, next_tx_req;
    logic [31:0] next_tx_frame;
    // lowest numbered pending object wins; filter re-evaluates every idle cycle,
    // so setting or re-setting any request bit retriggers it
    always_comb
    begin
        first_idx = 2'h0;
        for (int k = N - 1; k >= 0; k--)
            if (pend[k])
                first_idx = k[1:0];
        any_pend = |pend;
        copy_ok = tx_state == cmoc_pkg::CMOC_TX_COPY && pend[cur];
        send_ok = tx_state == cmoc_pkg::CMOC_TX_SEND && pend[cur] && tx_done;
        next_tx_state = tx_state;
        next_cur = cur;
        next_tx_req = tx_req;
        next_tx_frame = tx_frame;
        case (tx_state)
            cmoc_pkg::CMOC_TX_IDLE:
                if (any_pend)
                begin
                    next_cur = first_idx;
                    next_tx_state = cmoc_pkg::CMOC_TX_COPY;
                end
            cmoc_pkg::CMOC_TX_COPY:
                if (copy_ok)
                begin
                    next_tx_frame = obj_data[cur]; // buffer copy
                    next_tx_req = 1'b1;
                    next_tx_state = cmoc_pkg::CMOC_TX_SEND;
                end
                else
                    next_tx_state = cmoc_pkg::CMOC_TX_IDLE; // withdrawn, filter again
            cmoc_pkg::CMOC_TX_SEND:
                if (!pend[cur] || tx_done)
                begin
                    next_tx_req = 1'b0; // withdrawal or completion ends the send
                    next_tx_state = cmoc_pkg::CMOC_TX_IDLE;
                end
            default:
            begin
                next_tx_req = 1'b0;
                next_tx_state = cmoc_pkg::CMOC_TX_IDLE;
            end
        endcase
    end
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_state <= cmoc_pkg::CMOC_TX_IDLE;
            cur <= 2'h0;
            tx_req <= 1'b0;
            tx_frame <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            tx_state <= next_tx_state;
            cur <= next_cur;
            tx_req <= next_tx_req;
            tx_frame <= next_tx_frame;
        end
    end

    // ---------------- message objects ----------------
    // each object owns its own next-state logic, so a software clear of one valid
    // bit cannot reach a store or copy running on another object
    for (genvar i = 0; i < N; i++)
    begin : g_obj
        cmoc_pkg::cmoc_obj_t nx;
        logic [31:0] nd;
        logic ctl_wr, store_ok, copy_hit, done_hit;
        // transmit enables gate the request without touching valid
        assign pend[i] = obj[i].object_valid && obj[i].transmit_request_bit
            && obj[i].transmit_enable_a && obj[i].transmit_enable_b;
        always_comb
        begin
            nx = obj[i];
            nd = obj_data[i];
            ctl_wr = do_wr && aw_addr == `CMOC_CTL_BASE + 8'(4 * i) && w_strb[1:0] == 2'h3;
            // any object type is a legal store target, gated only by valid and rx enable
            store_ok = rx_store_valid && rx_store.idx == 2'(i) && obj[i].object_valid
                && obj[i].receive_enable_bit;
            copy_hit = copy_ok && cur == 2'(i);
            done_hit = send_ok && cur == 2'(i);
            if (ctl_wr)
                nx = w_data[`CMOC_CTL_W-1:0];
            if (do_wr && aw_addr == `CMOC_DAT_BASE + 8'(4 * i) && w_strb == 4'hF)
                nd = w_data;
            // hardware events are applied last so they win over a same-cycle write
            if (store_ok)
            begin
                nd = rx_store.data;
                nx.message_lost_flag = obj[i].new_data_flag; // unread data overwritten
                nx.new_data_flag = 1'b1;
                nx.receive_pending_flag = 1'b1;
            end
            if (copy_hit)
                nx.new_data_flag = 1'b0;
            if (done_hit)
                nx.transmit_request_bit = 1'b0;
            if ((store_ok || done_hit) && obj[i].single_data_transfer)
                nx.object_valid = 1'b0;
            ist_set[i] = store_ok; // receive interrupt
            ist_set[i + N] = done_hit;
        end
        always_ff @(posedge core_clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                obj[i] <= '0;
                obj_data[i] <= 32'h0000_0000;
            end
            else if (clk_en)
            begin
                obj[i] <= nx;
                obj_data[i] <= nd;
            end
        end
    end

    // ---------------- bit timing measurement and interrupts ----------------
    logic rx_s1, rx_s2, rx_d, tx_d;
    logic [`CMOC_FCV_W-1:0] since_dom, since_sp, since_txd, since_txr;
    logic rx_fall, rx_rise, tx_fall, tx_rise, meas, next_irq;
    always_comb
    begin
        rx_fall = rx_d && !rx_s2;
        rx_rise = !rx_d && rx_s2;
        tx_fall = tx_d && !tx_level;
        tx_rise = !tx_d && tx_level;
        meas = fcc.frame_counter_function_mode == `CMOC_MODE_MEAS;
        next_fcv = fcv; // value holds between qualifying events
        if (meas)
            case (fcc.measurement_submode_select)
                `CMOC_SUB_REC: if (rx_rise) next_fcv = since_dom;
                `CMOC_SUB_ECHO_DOM: if (rx_fall && !tx_level) next_fcv = since_txd;
                `CMOC_SUB_ECHO_REC: if (rx_rise && tx_level) next_fcv = since_txr;
                `CMOC_SUB_RESYNC: if (rx_fall && sync_qualify) next_fcv = since_sp;
                default: next_fcv = fcv;
            endcase
        next_fcc = fcc;
        next_imsk = imsk;
        next_ist = ist;
        if (do_wr && aw_addr == `CMOC_FCC_OFF && w_strb[0])
            next_fcc = w_data[`CMOC_FCC_W-1:0];
        if (do_wr && aw_addr == `CMOC_IMSK_OFF && w_strb[0])
            next_imsk = w_data[`CMOC_IST_W-1:0];
        if (do_wr && aw_addr == `CMOC_IST_OFF && w_strb[0])
            next_ist = ist & ~w_data[`CMOC_IST_W-1:0];
        next_ist = next_ist | ist_set; // a new event wins over the write-one clear
        next_irq = |(next_ist & next_imsk);
    end
    // edge distance counters restart at one on their edge, so a stretch of n cycles
    // reads n; a plain wrap is accepted since a bit time is far below the counter range
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            rx_d <= 1'b1;
            tx_d <= 1'b1;
            since_dom <= '0;
            since_sp <= '0;
            since_txd <= '0;
            since_txr <= '0;
            fcv <= '0;
            fcc <= '0;
            ist <= '0;
            imsk <= '0;
            irq <= 1'b0;
        end
        else if (clk_en)
        begin
            rx_s1 <= rxd_pin;
            rx_s2 <= rx_s1;
            rx_d <= rx_s2;
            tx_d <= tx_level;
            since_dom <= rx_fall ? 16'h0001 : since_dom + 1'b1;
            since_sp <= sample_point ? 16'h0001 : since_sp + 1'b1;
            since_txd <= tx_fall ? 16'h0001 : since_txd + 1'b1;
            since_txr <= tx_rise ? 16'h0001 : since_txr + 1'b1;
            fcv <= next_fcv;
            fcc <= next_fcc;
            ist <= next_ist;
            imsk <= next_imsk;
            irq <= next_irq;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge core_clk iff clk_en); endclocking
    default disable iff (!rst_n);
    sequence s_copy;
        tx_state == cmoc_pkg::CMOC_TX_COPY && pend[cur];
    endsequence
    sequence s_sending;
        tx_req && tx_state == cmoc_pkg::CMOC_TX_SEND && !obj[cur].new_data_flag;
    endsequence
    mode_gate_a: assert property (!meas |=> fcv == $past(fcv))
        else $error("frame counter value moved outside measurement mode");
    rec_edge_a: assert property (meas && fcc.measurement_submode_select == `CMOC_SUB_REC
        && rx_rise |=> fcv == $past(since_dom))
        else $error("recessive edge distance not stored");
    echo_dom_a: assert property (meas && fcc.measurement_submode_select == `CMOC_SUB_ECHO_DOM
        && rx_fall && !tx_level |=> fcv == $past(since_txd))
        else $error("dominant echo delay not stored");
    echo_rec_a: assert property (meas && fcc.measurement_submode_select == `CMOC_SUB_ECHO_REC
        && rx_rise && tx_level |=> fcv == $past(since_txr))
        else $error("recessive echo delay not stored");
    resync_a: assert property (meas && fcc.measurement_submode_select == `CMOC_SUB_RESYNC
        && rx_fall && sync_qualify |=> fcv == $past(since_sp))
        else $error("resync distance not stored");
    store_flags_a: assert property (rx_store_valid && obj[rx_store.idx].object_valid
        && obj[rx_store.idx].receive_enable_bit |=> obj[$past(rx_store.idx)].new_data_flag
        && obj[$past(rx_store.idx)].receive_pending_flag && ist[$past(rx_store.idx)])
        else $error("store did not update flags or interrupt");
    copy_send_a: assert property (s_copy |=> s_sending)
        else $error("copy did not clear new data and start sending");
    sdt_clear_a: assert property (send_ok && obj[cur].single_data_transfer
        |=> !obj[$past(cur)].object_valid)
        else $error("single transfer left object valid");
    withdraw_a: assert property (tx_state == cmoc_pkg::CMOC_TX_SEND && !pend[cur]
        |=> !tx_req && tx_state == cmoc_pkg::CMOC_TX_IDLE
        ##1 (tx_state == cmoc_pkg::CMOC_TX_COPY) == $past(any_pend))
        else $error("withdrawn request did not restart filtering");
endmodule
`default_nettype wire

// *** testbench/cmoc_node_model.sv ***
// node side model: answers transmit requests and paces bit timing pulses
`timescale 1ns/10ps
`default_nettype none
module cmoc_node_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // transmit handshake
    input wire logic tx_req,
    input wire logic [3:0] lat,
    output logic tx_done,
    // bit timing
    output logic tx_level,
    output logic sample_point
);
    logic [3:0] cnt; // cycles spent on the current frame
    logic [2:0] sp; // sample point divider
    // done comes lat cycles into a frame; a withdrawn frame restarts the count
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt <= 4'h0;
            tx_done <= 1'b0;
            tx_level <= 1'b1;
            sp <= 3'h0;
            sample_point <= 1'b0;
        end
        else
        begin
            tx_done <= tx_req && !tx_done && cnt == lat;
            cnt <= (tx_req && !tx_done && cnt != lat) ? cnt + 4'h1 : 4'h0;
            tx_level <= tx_req ? ~tx_level : 1'b1; // recessive outside frames
            sp <= sp + 3'h1;
            sample_point <= sp == 3'h0;
        end
    end
endmodule
`default_nettype wire

// *** testbench/cmoc_top_test.sv ***
// self-checking bench of the message object controller
`timescale 1ns/10ps
`default_nettype none
module cmoc_top_test;
    logic core_clk, resetn, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic rx_store_valid, tx_level, sample_point, sync_qualify, tx_done, tx_req, rxd_pin, irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, tx_frame, d, e, v;
    logic [3:0] s_axi_wstrb, lat;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    cmoc_pkg::cmoc_rx_frame_t rx_store;
    int n_errors, check_count, seed, i, j, n;
    cmoc_top uut (.core_clk, .resetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .rx_store_valid, .rx_store, .tx_level, .sample_point,
        .sync_qualify, .tx_done, .tx_req, .tx_frame, .rxd_pin, .irq);
    cmoc_node_model node (.core_clk, .resetn, .tx_req, .lat, .tx_done, .tx_level, .sample_point);
    // 4 ns clock
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // expected control word after one offered store: gated by valid and rx enable
    function automatic logic [31:0] rxv(input logic [31:0] c);
        rxv = c;
        if (c[0] && c[1])
        begin
            rxv = c | 32'h0000_0140 | {c[6], 7'h00};
            rxv[0] = !c[5];
        end
    endfunction
    // expected control word once a frame is sent
    function automatic logic [31:0] txd(input logic [31:0] c);
        txd = c & 32'hffff_ffaf;
        txd[0] = c[0] && !c[5];
    endfunction
    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] y);
        check_count++;
        if (y !== x)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", s, x, y);
        end
    endtask
    // one-bit outputs are looked at mid-cycle, where they are settled
    task automatic chkb(input string s, input logic x);
        @(negedge core_clk);
        check_count++;
        if (irq !== x)
        begin
            n_errors++;
            $display("[FAIL] %s expected %b seen %b", s, x, irq);
        end
        @(posedge core_clk);
    endtask
    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] x);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= x;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(ta && tw))
        begin
            @(negedge core_clk);
            ta = ta || s_axi_awready === 1'b1;
            tw = tw || s_axi_wready === 1'b1;
            @(posedge core_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b1;
        do @(negedge core_clk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        @(posedge core_clk);
        s_axi_bready <= 1'b0;
    endtask
    // read: data and response taken mid-cycle, at the first negedge where rvalid is seen high
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(negedge core_clk); while (s_axi_arready !== 1'b1);
        @(posedge core_clk);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(negedge core_clk); while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge core_clk);
        s_axi_rready <= 1'b0;
    endtask
    // one received frame from the node, then time to land
    task automatic st(input logic [1:0] k, input logic [31:0] x);
        rx_store_valid <= 1'b1;
        rx_store <= {k, x};
        @(posedge core_clk);
        rx_store_valid <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask
    // waits for the transmit buffer to fill or empty
    task automatic txw(input logic x);
        do @(negedge core_clk); while (tx_req !== x);
        @(posedge core_clk);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // hang guard, far beyond the few hundred cycles the tests need
    initial
    begin
        #200000;
        n_errors++;
        finish_test();
    end
    initial
    begin
        {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {rx_store_valid, sync_qualify, s_axi_awaddr, s_axi_araddr, rx_store} = 0;
        {s_axi_wdata, clk_en, rxd_pin, s_axi_wstrb, lat} = {32'h0000_0000, 2'b11, 4'hf, 4'hf};
        seed = 32'h0000_631e;
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(8'h10);
        chk("ctl0 reset", 32'h0000_0000, v);
        rd(8'h30);
        chk("unmapped rresp", 2'h2, r);
        chk("unmapped rdata", 32'h0000_0000, v);
        wr(8'h02, 32'h0000_0001);
        chk("misaligned bresp", 2'h2, r);
        $display("register map test done");
        wr(8'h0c, 32'h0000_00ff);
        // object types 0 to 4, rx enable off on obj2, single transfer forced on obj3
        for (i = 0; i < 5; i++)
        begin
            e = {20'h0_0000, 3'(i), 3'h0, (i == 3) || 1'($random(seed)), 3'h0, i != 2, 1'b1};
            wr(8'h10 + 8'(4 * (i % 4)), e);
            for (j = 0; j < 2; j++)
            begin
                v = $random(seed);
                st(2'(i % 4), v);
                if (e[0] && e[1]) d = v; // only a landing store replaces the data
                e = rxv(e);
            end
            rd(8'h10 + 8'(4 * (i % 4)));
            chk("rx ctl", e, v);
            rd(8'h08);
            chk("rx status", {31'h0000_0000, e[8]} << (i % 4), v);
            chkb("irq on store", e[8]);
            if (e[8]) rd(8'h20 + 8'(4 * (i % 4)));
            if (e[8]) chk("rx data", d, v);
            wr(8'h08, 32'h0000_00ff);
            chkb("irq cleared", 1'b0);
        end
        wr(8'h0c, 32'h0000_0000);
        st(2'h0, d);
        chkb("irq masked", 1'b0);
        wr(8'h08, 32'h0000_00ff);
        // software drops object 1 while object 0 stores
        wr(8'h10, 32'h0000_0003);
        d = $random(seed);
        fork
            wr(8'h14, 32'h0000_0000);
            begin
                @(posedge core_clk); // store lands on the edge of the valid clear
                st(2'h0, d);
            end
        join
        rd(8'h20);
        chk("store beside clear", d, v);
        wr(8'h08, 32'h0000_00ff);
        $display("receive test done");
        // single transfer send from object 2
        wr(8'h28, d);
        e = 32'h0000_007d;
        wr(8'h18, e);
        txw(1'b1);
        chk("tx frame", d, tx_frame);
        rd(8'h18);
        chk("ctl after copy", e & 32'hffff_ffbf, v);
        txw(1'b0);
        rd(8'h18);
        chk("ctl after send", txd(e), v);
        rd(8'h08);
        chk("tx status", 32'h0000_0040, v);
        // withdrawn winner must give way to object 1
        wr(8'h24, ~d);
        wr(8'h10, 32'h0000_001d);
        txw(1'b1);
        chk("winner frame", d, tx_frame);
        wr(8'h14, 32'h0000_001d);
        wr(8'h10, 32'h0000_000d);
        txw(1'b0);
        txw(1'b1);
        chk("refiltered frame", ~d, tx_frame);
        txw(1'b0);
        rd(8'h14);
        chk("ctl1 sent", 32'h0000_000d, v);
        rd(8'h10);
        chk("ctl0 still valid", 32'h0000_000d, v);
        $display("transmit test done");
        // recessive edge measures the dominant stretch
        wr(8'h00, 32'h0000_0006);
        n = 9 + {$random(seed)} % 30; // longer than any sample-point distance
        rxd_pin <= 1'b0;
        repeat (n) @(posedge core_clk);
        rxd_pin <= 1'b1;
        repeat (6) @(posedge core_clk);
        rd(8'h04);
        chk("dominant width", n, v);
        wr(8'h00, 32'h0000_0004);
        rxd_pin <= 1'b0;
        repeat (3) @(posedge core_clk);
        rxd_pin <= 1'b1;
        repeat (6) @(posedge core_clk);
        rd(8'h04);
        chk("value held", n, v);
        for (i = 1; i < 5; i++)
        begin
            wr(8'h00, {27'h000_0000, 3'(i), 2'h2});
            rd(8'h00);
            chk("sub-mode readback", {27'h000_0000, 3'(i), 2'h2}, v);
        end
        // last sub-mode written is resync: a qualified dominant edge lies one to
        // eight cycles after a sample point, which the dominant width never does
        sync_qualify <= 1'b1;
        rxd_pin <= 1'b0;
        repeat (6) @(posedge core_clk);
        {sync_qualify, rxd_pin} <= 2'b01;
        repeat (6) @(posedge core_clk);
        rd(8'h04);
        chk("resync distance", 32'h0000_0001, 32'(v - 32'h1 < 32'h8));
        $display("measurement test done");
        // a store offered while the clock enable is low must not land
        wr(8'h10, 32'h0000_0003);
        clk_en <= 1'b0;
        st(2'h0, ~d);
        clk_en <= 1'b1;
        rd(8'h20);
        chk("frozen store", d, v);
        $display("clock enable test done");
        finish_test();
    end
endmodule
`default_nettype wire
